// >>> verif/battery_charge_timer_control_tb.sv
/*
  Self-checking bench for bct_top with a mode model.
  Assumes pull-ups on the open-drain pins.
*/
`timescale 1ns/1ps
`default_nettype none
module battery_charge_timer_control_tb
  import bct_pkg::*;
;
  logic clk, rst_n = 1'h0, style = 1'h0, drain_n = 1'h1, live_en = 1'h1, live_pulse = 1'h0;
  logic go = 1'h0, lp = 1'h0, done, live, sel, tclk, chain, pos, neg, lamp_o, lamp_oe;
  logic flag_o, flag_oe, lamp_q, flag_q, m_full = 1'h0;
  logic [48:0] bits = 49'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sd, a0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int failures = 0, samples_checked = 0, tmo = 0, lamp_edges, pos_hi, flag_rises, flag_hi;
  int seed = 95, e1;
  bct_top i_bct_top (.sys_clk_i(clk), .arst_n_i(rst_n), .charger_live_i(live),
    .drain_detect_n_i(drain_n), .indication_style_i(style), .test_select_i(sel),
    .test_clock_in_i(tclk), .chain_in_i(chain), .charge_drive_pos_o(pos),
    .charge_drive_neg_o(neg), .status_lamp_n_o(lamp_o), .status_lamp_n_oe_o(lamp_oe),
    .low_battery_flag_n_o(flag_o), .low_battery_flag_n_oe_o(flag_oe), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  bct_partner i_bct_partner (.sys_clk_i(clk), .live_en_i(live_en), .live_pulse_i(live_pulse),
    .go_i(go), .loop_i(lp), .bits_i(bits), .flag_level_i(flag_oe ? flag_o : 1'h1),
    .charger_live_o(live), .test_select_o(sel), .test_clock_o(tclk), .chain_o(chain),
    .done_o(done));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic results();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_go, w_go, b_go;
    logic [1:0] br;
    n = 0;
    b_go = 1'h0;
    br = 2'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = (s_axi_bvalid === 1'h1);
      br = s_axi_bresp;
      @(posedge clk);
      n++;
      if (aw_go) s_axi_awvalid <= 1'h0;
      if (w_go) s_axi_wvalid <= 1'h0;
    end while (!b_go && n < 100);
    s_axi_bready <= 1'h0;
    if (!b_go) failures++;
    chk("bresp", 32'(er), 32'(br));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic ar_go, r_go;
    n = 0;
    r_go = 1'h0;
    d = 32'h0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = (s_axi_rvalid === 1'h1);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      n++;
      if (ar_go) s_axi_arvalid <= 1'h0;
    end while (!r_go && n < 100);
    s_axi_rready <= 1'h0;
    if (!r_go) failures++;
  endtask
  // Expected mode from the pin model
  function automatic logic [2:0] mmode();
    if (live_en !== 1'h1) return drain_n ? MODE_SELF : MODE_DISCH;
    if (drain_n !== 1'h1) return MODE_CHG_DIS;
    return m_full ? MODE_TRICKLE : MODE_CHARGE;
  endfunction
  task automatic st(input logic [9:0] c);
    rd(ADDR_STATUS, sd);
    chk("mode", 32'(mmode()), 32'(sd[18:16]));
    chk("count", 32'(c), 32'(sd[9:0]));
  endtask
  task automatic clr();
    @(negedge clk);
    lamp_edges = 0;
    pos_hi = 0;
    flag_rises = 0;
    flag_hi = 0;
  endtask
  task automatic wn(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic scan(input logic l, input logic [48:0] b);
    int n;
    n = 0;
    @(posedge clk);
    lp <= l;
    bits <= b;
    go <= 1'h1;
    repeat (3) @(posedge clk);
    while (done !== 1'h1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'h1) failures++;
    go <= 1'h0;
  endtask
  task automatic per(input logic [15:0] f, input logic [15:0] l);
    wr(ADDR_FILL, 32'(f), RESP_OKAY);
    wr(ADDR_DRAIN, 32'h1, RESP_OKAY);
    wr(ADDR_LEAK, 32'(l), RESP_OKAY);
  endtask
  task automatic rst(input logic s);
    @(posedge clk);
    rst_n <= 1'h0;
    style <= s;
    m_full = 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  always @(posedge clk) begin
    tmo <= tmo + 1;
    lamp_q <= lamp_oe;
    flag_q <= flag_oe;
    if (lamp_oe !== lamp_q) lamp_edges++;
    if (pos === 1'h1) pos_hi++;
    if (flag_oe === 1'h1) flag_hi++;
    if (flag_oe === 1'h1 && flag_q !== 1'h1) flag_rises++;
    if (tmo == 60000) begin
      failures++;
      results();
    end
  end
  initial begin
    rst(1'h0);
    wn(1);
    chk("drive_pos", 32'h1, 32'(pos));
    chk("drive_neg", 32'h0, 32'(neg));
    chk("lamp_on", 32'h1, 32'(lamp_oe));
    chk("lamp_level", 32'h0, 32'(lamp_o));
    st(10'h000);
    rd(ADDR_LEAK, sd);
    chk("leak_rst", 32'(PER_LEAK_RST), sd);
    rd(8'h10, sd);
    chk("bad_rresp", 32'(RESP_SLVERR), 32'(rr));
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    sd = $random(seed);
    wr(ADDR_FILL, sd, RESP_OKAY);
    rd(ADDR_FILL, a0);
    chk("fill_rw", 32'(sd[15:0]), a0);
    per(16'h1, 16'h1);
    clr();
    wn(9000);
    chk("lamp_steady", 32'h0, lamp_edges);
    rd(ADDR_STATUS, sd);
    chk("count_up", 32'h1, 32'(sd[9:0] >= 10'h001 && sd[9:0] <= 10'h003));
    @(posedge clk);
    drain_n <= 1'h0;
    clr();
    wn(1200);
    chk("alarm_off", 32'h0, lamp_edges);
    st(10'h000);
    @(posedge clk);
    live_en <= 1'h0;
    wn(600);
    chk("neg_inv", 32'h1, 32'(neg & ~pos));
    chk("lamp_open", 32'h0, 32'(lamp_oe));
    clr();
    @(posedge clk);
    drain_n <= 1'h1;
    wn(1500);
    chk("pulses", 32'h4, flag_rises);
    st(10'h000);
    wr(ADDR_FILL, 32'h0000FFFF, RESP_OKAY);
    @(posedge clk);
    drain_n <= 1'h0;
    wn(20);
    @(posedge clk);
    drain_n <= 1'h1;
    for (e1 = 0; flag_oe !== 1'h1 && e1 < 400; e1++) wn(1);
    @(posedge clk);
    live_en <= 1'h1;
    clr();
    wn(6);
    chk("cut_now", 32'h0, 32'(flag_oe));
    wn(600);
    chk("no_pulses", 32'h0, flag_rises);
    @(posedge clk);
    live_pulse <= 1'h1;
    wn(800);
    st(10'h000);
    scan(1'h0, {22'h3A5C3C, 17'h0F0F0, 10'h155});
    clr();
    scan(1'h1, 49'h0);
    chk("scan_drive", 32'h1, 32'(flag_hi > 550));
    st(10'h155);
    per(16'h2, 16'h3);
    scan(1'h0, 49'h3FF);
    m_full = 1'h1;
    wn(20);
    st(10'h3FF);
    clr();
    wn(170);
    chk("trickle_duty", 32'd80, pos_hi);
    clr();
    wn(3000);
    chk("trickle_blink", 32'h1, 32'(lamp_edges > 0));
    rst(1'h1);
    per(16'h1, 16'h1);
    clr();
    wn(2048);
    e1 = lamp_edges;
    chk("slow_blink", 32'h1, 32'(e1 > 4));
    @(posedge clk);
    drain_n <= 1'h0;
    wn(20);
    clr();
    wn(2048);
    chk("alarm_blink", 32'h1, 32'(lamp_edges > 8 * e1));
    @(posedge clk);
    drain_n <= 1'h1;
    scan(1'h0, 49'h3FF);
    m_full = 1'h1;
    wn(20);
    clr();
    wn(1000);
    chk("trickle_on", 32'h1, 32'(lamp_edges == 0 && lamp_oe === 1'h1));
    results();
  end
endmodule
`default_nettype wire

// >>> verif/bct_partner.sv
/*
  Charger and tester model: live sense level or pulses, scan frames.
  Assumes the flag pin level is resolved by the bench with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module bct_partner (
  input wire logic sys_clk_i,
  input wire logic live_en_i,
  input wire logic live_pulse_i,
  input wire logic go_i,
  input wire logic loop_i,
  input wire logic [48:0] bits_i,
  input wire logic flag_level_i,
  output logic charger_live_o,
  output logic test_select_o,
  output logic test_clock_o,
  output logic chain_o,
  output logic done_o
);
  logic [7:0] ph_reg = 8'h00;
  logic tgl_reg = 1'h0;
  logic go_q = 1'h0;
  initial begin
    test_select_o = 1'h0;
    test_clock_o = 1'h0;
    chain_o = 1'h0;
    done_o = 1'h0;
  end
  // Steady level or 100 kHz square wave
  assign charger_live_o = live_en_i & (~live_pulse_i | tgl_reg);
  always @(posedge sys_clk_i) begin
    go_q <= go_i;
    ph_reg <= (ph_reg == 8'h63) ? 8'h00 : ph_reg + 8'h01;
    if (ph_reg == 8'h63) tgl_reg <= ~tgl_reg;
  end
  // One frame per rising go; data line wanders outside frames
  always @(posedge sys_clk_i) begin
    if (go_i && !go_q) begin
      done_o <= 1'h0;
      test_select_o <= 1'h1;
      repeat (6) @(posedge sys_clk_i);
      for (int i = 0; i < 49; i++) begin
        repeat (3) @(posedge sys_clk_i);
        chain_o <= loop_i ? flag_level_i : bits_i[48-i];
        repeat (3) @(posedge sys_clk_i);
        test_clock_o <= 1'h1;
        repeat (6) @(posedge sys_clk_i);
        test_clock_o <= 1'h0;
      end
      repeat (6) @(posedge sys_clk_i);
      test_select_o <= 1'h0;
      done_o <= 1'h1;
    end else begin
      chain_o <= ~chain_o;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/bct_pkg.sv
/*
  Shared constants for the battery charge timer: counter and divider
  sizes, indicator taps, timing figures, register map and mode codes.
  Assumes a single 20 MHz system clock.
*/
package bct_pkg;
  localparam int CNT_W = 10;
  localparam int DIV_W = 17;
  localparam int AUX_W = 22;
  localparam int CHAIN_LEN = AUX_W + DIV_W + CNT_W;
  localparam int SEC_CHARGE = 22;
  localparam int SEC_DRAIN = 18;
  localparam int SEC_LEAK = 27;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
  localparam logic [CNT_W-1:0] CNT_MIN = 10'h000;
  localparam logic [2:0] TRICKLE_FILL_PERIODS = 3'h4;
  localparam logic [2:0] TRICKLE_LEAK_PERIODS = 3'h3;
  localparam logic [2:0] TRICKLE_LAST = 3'(TRICKLE_FILL_PERIODS + TRICKLE_LEAK_PERIODS - 3'h1);
  localparam logic [3:0] LOWBAT_LAST_HALF = 4'h7;
  localparam int TAP_ALARM = 3;
  localparam int TAP_1HZ = 5;
  localparam int TAP_QUARTER = 7;
  localparam int SYS_CLK_MHZ = 20;
  localparam int LIVE_HOLD_NS = 20000;
  localparam int LIVE_HOLD_CYC = (LIVE_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LIVE_HOLD_W = $clog2(LIVE_HOLD_CYC + 1);
  localparam int PER_W = 16;
  localparam logic [PER_W-1:0] PER_FILL_RST = 16'h0010;
  localparam logic [PER_W-1:0] PER_DRAIN_RST = 16'h0008;
  localparam logic [PER_W-1:0] PER_LEAK_RST = 16'h0020;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FILL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DRAIN = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_LEAK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_FULL = 20;
  localparam int ST_EMPTY = 21;
  localparam int ST_LOWBAT = 22;
  localparam int ST_LIVE = 23;
  localparam int ST_SCAN = 24;
  typedef enum logic [2:0] {
    MODE_CHARGE = 3'h0,
    MODE_TRICKLE = 3'h1,
    MODE_CHG_DIS = 3'h3,
    MODE_DISCH = 3'h2,
    MODE_SELF = 3'h6
  } bct_mode_t;
endpackage

// >>> verilog/bct_sync.sv
/*
  Two-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level or a clock slower than half sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module bct_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/bct_tick_gen.sv
/*
  Programmable oscillator model: one-cycle tick every period_i cycles.
  Assumes period_i may change at any time; it takes effect at reload.
*/
`timescale 1ns/1ps
`default_nettype none
module bct_tick_gen
  import bct_pkg::*;
#(
  parameter int WIDTH = PER_W
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] period_i,
  output logic tick_o
);
  logic [WIDTH-1:0] left_reg;
  wire expired = (left_reg == '0);
  // Zero period behaves as one
  wire [WIDTH-1:0] reload = (period_i == '0) ? '0 : WIDTH'(period_i - 1'b1);

  assign tick_o = run_i && expired;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left_reg <= '0;
    end else if (!run_i || expired) begin
      left_reg <= reload;
    end else begin
      left_reg <= WIDTH'(left_reg - 1'b1);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/bct_top.sv
/*
  Battery charge timer control: mode selection, up/down divider-counter,
  charge drive, status lamp, low-battery pulses, scan chain, AXI4-Lite
  register slave. Assumes outside pull resistors resolve open-drain pins
  and a floating indication_style pin reads high.
*/
// What this block does
// - Drain high, charger idle: self-discharge, count down on leak rate, hold at zero.
// - Style low: lamp steady on while charging, about 1 Hz blink in trickle.
// - Style high: lamp blinks about 0.25 Hz charging, steady on in trickle.
// - Discharge modes leave lamp open unless charger is live.
// - Drain rising after discharge stopped at zero: four one-second 50% low pulses.
// - Charger becoming live cuts the low pulses at once, pin released.
// - Style high, charge and discharge together: lamp alarm blinks about 4 Hz.
// - Style low: no alarm, lamp steady on during charge with discharge.
// - Test select high: oscillator bypassed, chain clocked from the test clock.
// - In test mode bits enter on chain_in and leave on the flag pin.
// - Looped chain with exactly 49 test clocks restores the state intact.
// - Charge mode drives positive enable high, counts up over 22 sections.
// - Discharge modes count down over 18 sections on drain rate, stop at zero.
// - Self-discharge counts down over 27 sections, the slowest rate.
// - Negative enable is always the inverse of the positive enable.
// - Charge counts up from zero on fill rate, stops at max, then trickles.
// - Trickle alternates four fill periods with three leak periods.
// - Reset clears the counter and starts in charge mode.
// - Charger live when high or toggling up to 100 kHz, idle when low.
`timescale 1ns/1ps
`default_nettype none
module bct_top
  import bct_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic charger_live_i,
  input wire logic drain_detect_n_i,
  input wire logic indication_style_i,
  input wire logic test_select_i,
  input wire logic test_clock_in_i,
  input wire logic chain_in_i,
  output logic charge_drive_pos_o,
  output logic charge_drive_neg_o,
  output logic status_lamp_n_o,
  output logic status_lamp_n_oe_o,
  output logic low_battery_flag_n_o,
  output logic low_battery_flag_n_oe_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // True when the low n bits of v are all ones
  function automatic logic low_ones(input logic [AUX_W-1:0] v, input int n);
    logic [AUX_W-1:0] m;
    m = AUX_W'((32'h1 << n) - 32'h1);
    return (v & m) == m;
  endfunction

  function automatic logic [PER_W-1:0] strb_merge(input logic [PER_W-1:0] old,
                                                   input logic [31:0] d,
                                                   input logic [3:0] s);
    logic [PER_W-1:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Pin synchronisers
  logic [5:0] pin_s;
  bct_sync #(.WIDTH(6)) u_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({charger_live_i, drain_detect_n_i, indication_style_i,
              test_select_i, test_clock_in_i, chain_in_i}),
    .sync_o(pin_s)
  );
  wire live_s = pin_s[5];
  wire drain_n_s = pin_s[4];
  wire style_s = pin_s[3];
  wire scan_s = pin_s[2];
  wire tclk_s = pin_s[1];
  wire chain_in_s = pin_s[0];

  logic tclk_d_reg;
  logic [1:0] settle_reg;
  logic drain_d_reg;
  logic [LIVE_HOLD_W-1:0] live_hold_reg;
  logic [LIVE_HOLD_W-1:0] live_hold_next;
  bct_mode_t mode_reg;
  bct_mode_t mode_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [AUX_W-1:0] aux_reg;
  logic [AUX_W-1:0] aux_next;
  logic [2:0] trk_reg;
  logic [2:0] trk_next;
  logic empty_reg;
  logic lb_active_reg;
  logic [3:0] lb_half_reg;
  logic [PER_W-1:0] per_fill_reg;
  logic [PER_W-1:0] per_drain_reg;
  logic [PER_W-1:0] per_leak_reg;

  // Charger presence stretched across gaps of a pulsed supply
  assign live_hold_next = live_s ? LIVE_HOLD_W'(LIVE_HOLD_CYC) :
                          (live_hold_reg != '0) ? LIVE_HOLD_W'(live_hold_reg - 1'b1) : '0;
  wire live = (live_hold_reg != '0);
  wire full = (cnt_reg == CNT_MAX);
  wire at_min = (cnt_reg == CNT_MIN);
  wire trk_fill = (trk_reg < TRICKLE_FILL_PERIODS);
  // Mode held in charge until the pin synchronisers have filled
  wire settled = &settle_reg;

  always_comb begin
    if (live && drain_n_s) begin
      mode_next = full ? MODE_TRICKLE : MODE_CHARGE;
    end else if (live) begin
      mode_next = MODE_CHG_DIS;
    end else if (!drain_n_s) begin
      mode_next = MODE_DISCH;
    end else begin
      mode_next = MODE_SELF;
    end
  end

  // Oscillator rate chosen by mode; a tick loads the period of the phase that follows
  logic osc_tick;
  wire [2:0] trk_ahead = (mode_reg == MODE_TRICKLE && osc_tick) ? trk_next : trk_reg;
  wire use_fill = (mode_reg == MODE_CHARGE) ||
                  (mode_reg == MODE_TRICKLE && trk_ahead < TRICKLE_FILL_PERIODS);
  wire use_drain = (mode_reg == MODE_CHG_DIS) || (mode_reg == MODE_DISCH);
  wire [PER_W-1:0] osc_period = use_fill ? per_fill_reg :
                                use_drain ? per_drain_reg : per_leak_reg;
  bct_tick_gen #(.WIDTH(PER_W)) u_osc (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .run_i(!scan_s),
    .period_i(osc_period),
    .tick_o(osc_tick)
  );
  wire scan_shift = scan_s && tclk_s && !tclk_d_reg;

  // Divider sections below the counter for each mode
  wire step_up = low_ones(AUX_W'(div_reg), SEC_CHARGE - CNT_W);
  wire step_drain = low_ones(AUX_W'(div_reg), SEC_DRAIN - CNT_W);
  wire step_leak = low_ones(AUX_W'(div_reg), SEC_LEAK - CNT_W);
  wire step_down = (mode_reg == MODE_SELF) ? step_leak : step_drain;
  wire counting = (mode_reg == MODE_CHARGE) ? !full :
                  (mode_reg == MODE_TRICKLE) ? 1'b0 : !at_min;

  wire [CHAIN_LEN-1:0] chain = {aux_reg, div_reg, cnt_reg};
  wire [CHAIN_LEN-1:0] chain_shifted = {chain[CHAIN_LEN-2:0], chain_in_s};

  always_comb begin
    cnt_next = cnt_reg;
    div_next = div_reg;
    aux_next = aux_reg;
    trk_next = trk_reg;
    if (scan_shift) begin
      {aux_next, div_next, cnt_next} = chain_shifted;
    end else if (osc_tick) begin
      aux_next = AUX_W'(aux_reg + 1'b1);
      if (counting) begin
        div_next = DIV_W'(div_reg + 1'b1);
        if (mode_reg == MODE_CHARGE && step_up) begin
          cnt_next = CNT_W'(cnt_reg + 1'b1);
        end else if (mode_reg != MODE_CHARGE && step_down) begin
          cnt_next = CNT_W'(cnt_reg - 1'b1);
        end
      end
      if (mode_reg == MODE_TRICKLE) begin
        trk_next = (trk_reg == TRICKLE_LAST) ? 3'h0 : 3'(trk_reg + 1'b1);
      end
    end
  end

  // Low-battery pulse train paced by a one-second tap
  wire lb_roll = osc_tick && !scan_s && low_ones(aux_reg, TAP_1HZ);
  wire drain_rise = drain_n_s && !drain_d_reg;
  wire lb_start = empty_reg && drain_rise && !live;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tclk_d_reg <= 1'b0;
      settle_reg <= '0;
      drain_d_reg <= 1'b0;
      live_hold_reg <= '0;
      mode_reg <= MODE_CHARGE;
      cnt_reg <= CNT_MIN;
      div_reg <= '0;
      aux_reg <= '0;
      trk_reg <= 3'h0;
    end else begin
      tclk_d_reg <= tclk_s;
      drain_d_reg <= drain_n_s;
      live_hold_reg <= live_hold_next;
      settle_reg <= settled ? settle_reg : 2'(settle_reg + 1'b1);
      mode_reg <= settled ? mode_next : mode_reg;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      aux_reg <= aux_next;
      trk_reg <= (mode_reg == MODE_TRICKLE) ? trk_next : 3'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      empty_reg <= 1'b0;
      lb_active_reg <= 1'b0;
      lb_half_reg <= 4'h0;
    end else begin
      if (mode_reg == MODE_DISCH && at_min) begin
        empty_reg <= 1'b1;
      end else if (lb_start || live) begin
        empty_reg <= 1'b0;
      end
      if (live) begin
        lb_active_reg <= 1'b0;
      end else if (lb_start) begin
        lb_active_reg <= 1'b1;
        lb_half_reg <= 4'h0;
      end else if (lb_active_reg && lb_roll) begin
        lb_active_reg <= (lb_half_reg != LOWBAT_LAST_HALF);
        lb_half_reg <= 4'(lb_half_reg + 1'b1);
      end
    end
  end

  // Pins
  assign charge_drive_pos_o = (mode_reg == MODE_CHARGE) || (mode_reg == MODE_CHG_DIS) ||
                              (mode_reg == MODE_TRICKLE && trk_fill);
  assign charge_drive_neg_o = !charge_drive_pos_o;

  logic lamp_on;
  always_comb begin
    case (mode_reg)
      MODE_CHARGE: lamp_on = style_s ? aux_reg[TAP_QUARTER] : 1'b1;
      MODE_TRICKLE: lamp_on = style_s ? 1'b1 : aux_reg[TAP_1HZ];
      MODE_CHG_DIS: lamp_on = style_s ? aux_reg[TAP_ALARM] : 1'b1;
      default: lamp_on = 1'b0;
    endcase
  end
  assign status_lamp_n_o = 1'b0;
  assign status_lamp_n_oe_o = lamp_on;

  wire lb_low = lb_active_reg && !lb_half_reg[0];
  assign low_battery_flag_n_o = scan_s ? aux_reg[AUX_W-1] : 1'b0;
  assign low_battery_flag_n_oe_o = scan_s || lb_low;

  // AXI4-Lite slave
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_fill = wr_go && (aw_addr_reg == ADDR_FILL);
  wire wr_drain = wr_go && (aw_addr_reg == ADDR_DRAIN);
  wire wr_leak = wr_go && (aw_addr_reg == ADDR_LEAK);
  wire wr_ok = wr_fill || wr_drain || wr_leak;
  wire rd_go = s_axi_arvalid && s_axi_arready;

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[CNT_W-1:0] = cnt_reg;
    status_word[ST_MODE_LSB +: 3] = mode_reg;
    status_word[ST_FULL] = full;
    status_word[ST_EMPTY] = empty_reg;
    status_word[ST_LOWBAT] = lb_active_reg;
    status_word[ST_LIVE] = live;
    status_word[ST_SCAN] = scan_s;
  end
  wire rd_hit = (s_axi_araddr == ADDR_FILL) || (s_axi_araddr == ADDR_DRAIN) ||
                (s_axi_araddr == ADDR_LEAK) || (s_axi_araddr == ADDR_STATUS);
  wire [31:0] rd_word = (s_axi_araddr == ADDR_FILL) ? 32'(per_fill_reg) :
                        (s_axi_araddr == ADDR_DRAIN) ? 32'(per_drain_reg) :
                        (s_axi_araddr == ADDR_LEAK) ? 32'(per_leak_reg) :
                        (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_fill_reg <= PER_FILL_RST;
      per_drain_reg <= PER_DRAIN_RST;
      per_leak_reg <= PER_LEAK_RST;
    end else begin
      if (wr_fill) per_fill_reg <= strb_merge(per_fill_reg, w_data_reg, w_strb_reg);
      if (wr_drain) per_drain_reg <= strb_merge(per_drain_reg, w_data_reg, w_strb_reg);
      if (wr_leak) per_leak_reg <= strb_merge(per_leak_reg, w_data_reg, w_strb_reg);
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_self_hold_zero: assert property ((mode_reg == MODE_SELF && at_min && !scan_s)
    |=> (cnt_reg == CNT_MIN)) else $error("self-discharge left zero");
  a_lamp_open_dis: assert property ((mode_reg == MODE_DISCH || mode_reg == MODE_SELF)
    |-> !status_lamp_n_oe_o) else $error("lamp driven in discharge");
  a_lamp_no_alarm: assert property ((!style_s && mode_reg == MODE_CHG_DIS)
    |-> status_lamp_n_oe_o) else $error("alarm blink with style low");
  a_lowbat_cut: assert property ((live && lb_active_reg)
    |=> !lb_active_reg && !low_battery_flag_n_oe_o [*2]) else $error("pulses not cut");
  a_scan_out_bit: assert property (scan_shift && $past(scan_s)
    |=> (low_battery_flag_n_o == $past(chain[CHAIN_LEN-2]))) else $error("scan out wrong");
  a_charge_up_only: assert property ((mode_reg == MODE_CHARGE && !scan_s)
    |=> (cnt_reg >= $past(cnt_reg)) && (cnt_reg - $past(cnt_reg) <= 10'h001))
    else $error("charge count not monotonic");
  a_drain_stop_min: assert property ((mode_reg == MODE_DISCH && at_min && !scan_s)
    |=> (cnt_reg == CNT_MIN)) else $error("discharge passed zero");
  a_drive_inverse: assert property (charge_drive_neg_o != charge_drive_pos_o)
    else $error("enables not inverse");
  a_trickle_split: assert property ((mode_reg == MODE_TRICKLE && trk_reg == TRICKLE_LAST)
    |-> !charge_drive_pos_o && !use_drain && (osc_tick || !use_fill))
    else $error("trickle phase wrong");
  a_live_hold: assert property (live_s |=> live [*8]) else $error("live dropped");
endmodule
`default_nettype wire
